// ===== rtl/ifpd_buf.sv
`timescale 1ns/1ps
`default_nettype none
module ifpd_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = count != (AW+1)'(DEPTH);
  assign out_valid = count != '0;
  assign out_data = mem[rd_ptr];

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) wr_ptr <= bump(wr_ptr);
      if (pop) rd_ptr <= bump(rd_ptr);
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge clk) begin
    if (push) mem[wr_ptr] <= in_data;
  end
endmodule // ifpd_buf
`default_nettype wire

// ===== rtl/ifpd_front.sv
// How it works
// - fetch reads 16-byte packets on 16-byte aligned addresses
// - packets merge into a 32-byte pick window
// - at most three instructions picked per cycle, in program order
// - budget: three singles or one and a half doubles per cycle
// - a microcoded instruction decodes alone, no fast ones beside it
// - 64-bit mode exposes sixteen vector regs; 8 to 15 only there
// - stack instructions address only eight registers
// - 32-bit gpr write clears bits 63 to 32
// - prefix required for 64-bit gpr operands and added gpr low halves
// - load-execute loads into internal temp, then operates
// - most integer load-execute decode fast, three per cycle
// - fp load-execute with fp operand yields fewer macro-ops
// - fp load-execute with integer operand: microcoded, two uops
// - 32/64-bit address calc fast, latency two; 16-bit microcoded
`timescale 1ns/1ps
`default_nettype none
module ifpd_front #(
  parameter int BUF_DEPTH = 2
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic mode64,
  input wire logic redirect_valid,
  input wire logic [63:0] redirect_addr,
  output logic [59:0] fetch_line,
  input wire logic pkt_valid,
  output logic pkt_ready,
  input wire logic [127:0] pkt_data,
  output logic dec_valid,
  input wire logic dec_ready,
  output logic [2:0] dec_slot_valid,
  output logic [2:0] dec_micro,
  output logic [8:0] dec_class,
  output logic [11:0] dec_reg,
  output logic [5:0] dec_size,
  output logic [5:0] dec_uops,
  output logic [8:0] dec_lat,
  output logic [2:0] dec_load_first,
  output logic [2:0] dec_zext,
  output logic [2:0] dec_fault,
  input wire logic wb_valid,
  input wire logic [1:0] wb_size,
  input wire logic [63:0] wb_data,
  input wire logic [63:0] wb_old,
  output logic wb_out_valid,
  output logic [63:0] wb_out_data
);
  localparam int SW = ifpd_pkg::SLOT_W;
  localparam int BW = SW * ifpd_pkg::MAX_SLOTS;

  logic rst_meta_n;
  logic rst_n;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  // window bytes are packed low first; bytes at or above win_cnt are zero
  logic [255:0] win;
  logic [5:0] win_cnt;
  logic [3:0] skip;
  logic [255:0] next_win;
  logic [5:0] next_cnt;

  function automatic logic [23:0] peek3(input logic [255:0] w,
                                        input logic [6:0] off);
    logic [255:0] sh;
    sh = w >> {off, 3'h0};
    peek3 = sh[23:0];
  endfunction

  logic [4:0] len [3];
  logic [3:0] wgt [3];
  logic [2:0] mic;
  logic [SW-1:0] fld [3];
  logic [6:0] off [4];

  assign off[0] = 7'h00;

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_slot
      wire [23:0] slot_bytes = peek3(win, off[g]);
      ifpd_slot_dec u_dec (
        .bytes3(slot_bytes),
        .mode64(mode64),
        .len(len[g]),
        .weight(wgt[g]),
        .micro(mic[g]),
        .fields(fld[g])
      );
      assign off[g+1] = off[g] + 7'(len[g]);
    end
  endgenerate

  // a slot counts only once its last byte is in the window
  wire [2:0] whole;
  assign whole[0] = off[1] <= 7'(win_cnt);
  assign whole[1] = off[2] <= 7'(win_cnt);
  assign whole[2] = off[3] <= 7'(win_cnt);

  wire [4:0] sum01 = 5'(wgt[0]) + 5'(wgt[1]);
  wire [4:0] sum012 = sum01 + 5'(wgt[2]);

  // in order: a slot is taken only if every earlier one was
  wire [2:0] take;
  assign take[0] = whole[0] && !redirect_valid;
  // microcoded pick stands alone in its cycle
  // half-unit budget caps singles at three and doubles at 1.5
  assign take[1] = take[0] && whole[1] && !mic[0] && !mic[1] &&
                   (sum01 <= 5'(ifpd_pkg::SLOT_BUDGET));
  assign take[2] = take[1] && whole[2] && !mic[2] &&
                   (sum012 <= 5'(ifpd_pkg::SLOT_BUDGET));

  logic buf_in_ready;
  wire go = take[0] && buf_in_ready;
  wire [6:0] used = !go ? 7'h00 :
                    take[2] ? off[3] :
                    take[1] ? off[2] : off[1];

  // accept a packet only while it fits whole in the window
  assign pkt_ready = rst_n && !redirect_valid &&
                     (win_cnt <= 6'(ifpd_pkg::PKT_BYTES));
  wire pkt_take = pkt_valid && pkt_ready;
  wire [4:0] pkt_len = 5'(ifpd_pkg::PKT_BYTES) - 5'(skip);
  wire [127:0] pkt_trim = pkt_data >> {skip, 3'h0};
  wire [5:0] keep_cnt = win_cnt - 6'(used);
  wire [255:0] kept = win >> {used, 3'h0};
  wire [255:0] pkt_wide = {128'h0, pkt_trim};

  always_comb begin
    next_win = kept;
    next_cnt = keep_cnt;
    if (pkt_take) begin
      next_win = kept | (pkt_wide << {keep_cnt, 3'h0});
      next_cnt = keep_cnt + 6'(pkt_len);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      win <= '0;
      win_cnt <= '0;
      skip <= '0;
      fetch_line <= '0;
    end else if (redirect_valid) begin
      // flush window; first packet drops bytes before the target
      win <= '0;
      win_cnt <= '0;
      // line address only, low four bits become the skip
      fetch_line <= redirect_addr[63:ifpd_pkg::PKT_SHIFT];
      skip <= redirect_addr[ifpd_pkg::PKT_SHIFT-1:0];
    end else begin
      win <= next_win;
      win_cnt <= next_cnt;
      if (pkt_take) begin
        fetch_line <= fetch_line + 60'h1;
        skip <= '0;
      end
    end
  end

  // bundle of three slots; slot valid bit is the low field bit
  logic [BW-1:0] bun_in;
  logic [BW-1:0] bun_out;
  always_comb begin
    bun_in = '0;
    for (int i = 0; i < 3; i++) begin
      if (take[i]) bun_in[i*SW +: SW] = fld[i];
    end
  end

  // short buffer so a stalled scheduler loses no bundle
  ifpd_buf #(
    .WIDTH(BW),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .clk(ref_clk),
    .rst_n(rst_n),
    .in_valid(take[0]),
    .in_ready(buf_in_ready),
    .in_data(bun_in),
    .out_valid(dec_valid),
    .out_ready(dec_ready),
    .out_data(bun_out)
  );

  generate
    for (g = 0; g < 3; g++) begin : g_out
      wire [SW-1:0] f = bun_out[g*SW +: SW];
      assign dec_slot_valid[g] = dec_valid && f[0];
      assign dec_micro[g] = f[1];
      assign dec_class[g*3 +: 3] = f[4:2];
      assign dec_reg[g*4 +: 4] = f[8:5];
      assign dec_size[g*2 +: 2] = f[10:9];
      assign dec_uops[g*2 +: 2] = f[12:11];
      assign dec_lat[g*3 +: 3] = f[15:13];
      assign dec_load_first[g] = f[16];
      assign dec_zext[g] = f[17];
      assign dec_fault[g] = f[18];
    end
  endgenerate

  // register write formatting; 8- and 16-bit writes merge with the old value
  logic [63:0] next_wb;
  always_comb begin
    unique case (wb_size)
      ifpd_pkg::ifpd_sz_8: next_wb = {wb_old[63:8], wb_data[7:0]};
      ifpd_pkg::ifpd_sz_16: next_wb = {wb_old[63:16], wb_data[15:0]};
      // upper half cleared on 32-bit write
      ifpd_pkg::ifpd_sz_32: next_wb = {32'h0, wb_data[31:0]};
      ifpd_pkg::ifpd_sz_64: next_wb = wb_data;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_out_valid <= 1'b0;
      wb_out_data <= '0;
    end else begin
      wb_out_valid <= wb_valid;
      if (wb_valid) wb_out_data <= next_wb;
    end
  end
endmodule // ifpd_front
`default_nettype wire

// ===== rtl/ifpd_pkg.sv
package ifpd_pkg;

  localparam int WIN_BYTES = 32;
  localparam int PKT_BYTES = 16;
  localparam int PKT_SHIFT = 4;
  localparam int MAX_SLOTS = 3;

  // decode budget in half-instruction units: 3 singles or 1.5 doubles
  localparam logic [3:0] SLOT_BUDGET = 4'h6;
  localparam logic [3:0] W_SINGLE = 4'h2;
  localparam logic [3:0] W_DOUBLE = 4'h4;
  localparam logic [3:0] W_MICRO = 4'h6;

  localparam logic [2:0] LAT_BASE = 3'h1;
  localparam logic [2:0] LAT_ADDR_CALC = 3'h2;
  localparam logic [1:0] UOPS_ONE = 2'h1;
  localparam logic [1:0] UOPS_TWO = 2'h2;
  localparam logic [1:0] UOPS_MICRO = 2'h3;

  // register-extension prefix byte: upper nibble fixed, low nibble flags
  localparam logic [3:0] PFX_HI = 4'h4;
  localparam int PFX_W_BIT = 3;
  localparam int PFX_B_BIT = 0;

  // header byte: length in [3:0], class in [6:4]
  localparam int HDR_LEN_LSB = 0;
  localparam int HDR_CLS_LSB = 4;
  localparam logic [3:0] MIN_LEN = 4'h2;

  // operand byte: size [1:0], register file [4:3], register [7:5]
  localparam int OPB_SZ_LSB = 0;
  localparam int OPB_RF_LSB = 3;
  localparam int OPB_REG_LSB = 5;

  typedef enum logic [2:0] {
    ifpd_cls_int_alu = 3'h0,
    ifpd_cls_int_ldex = 3'h1,
    ifpd_cls_double = 3'h2,
    ifpd_cls_fp_ldex_fp = 3'h3,
    ifpd_cls_fp_ldex_int = 3'h4,
    ifpd_cls_addr_calc = 3'h5,
    ifpd_cls_micro = 3'h6,
    ifpd_cls_bad = 3'h7
  } ifpd_cls_t;

  typedef enum logic [1:0] {
    ifpd_sz_16 = 2'h0,
    ifpd_sz_32 = 2'h1,
    ifpd_sz_64 = 2'h2,
    ifpd_sz_8 = 2'h3
  } ifpd_size_t;

  typedef enum logic [1:0] {
    ifpd_rf_gpr = 2'h0,
    ifpd_rf_vec = 2'h1,
    ifpd_rf_stack = 2'h2,
    ifpd_rf_none = 2'h3
  } ifpd_rf_t;

  // per-slot decoded fields packed for the output buffer
  localparam int SLOT_W = 20;

endpackage

// ===== rtl/ifpd_slot_dec.sv
`timescale 1ns/1ps
`default_nettype none
module ifpd_slot_dec (
  input wire logic [23:0] bytes3,
  input wire logic mode64,
  output logic [4:0] len,
  output logic [3:0] weight,
  output logic micro,
  output logic [19:0] fields
);
  wire [7:0] b0 = bytes3[7:0];
  wire [7:0] b1 = bytes3[15:8];
  wire [7:0] b2 = bytes3[23:16];
  // prefix is only recognised in 64-bit mode
  wire has_pfx = mode64 && (b0[7:4] == ifpd_pkg::PFX_HI);
  wire [7:0] hdr = has_pfx ? b1 : b0;
  wire [7:0] opb = has_pfx ? b2 : b1;
  wire [3:0] pfx = has_pfx ? b0[3:0] : 4'h0;
  wire [3:0] raw_len = hdr[ifpd_pkg::HDR_LEN_LSB +: 4];
  wire [3:0] body_len = (raw_len < ifpd_pkg::MIN_LEN) ?
                        ifpd_pkg::MIN_LEN : raw_len;
  wire [2:0] cls = hdr[ifpd_pkg::HDR_CLS_LSB +: 3];
  wire [1:0] sz = opb[ifpd_pkg::OPB_SZ_LSB +: 2];
  wire [1:0] rf = opb[ifpd_pkg::OPB_RF_LSB +: 2];
  wire [2:0] reg_lo = opb[ifpd_pkg::OPB_REG_LSB +: 3];
  wire is_gpr = rf == ifpd_pkg::ifpd_rf_gpr;
  wire is_stack = rf == ifpd_pkg::ifpd_rf_stack;
  wire pfx_w = pfx[ifpd_pkg::PFX_W_BIT];
  // stack regs only: three bits, prefix ignored
  wire reg_hi = is_stack ? 1'b0 : pfx[ifpd_pkg::PFX_B_BIT];
  // vector regs 8..15 reachable only through the 64-bit-mode prefix
  wire [3:0] reg_idx = {reg_hi, reg_lo};
  wire is_size64 = sz == ifpd_pkg::ifpd_sz_64;
  // 64-bit gpr operand needs the prefix; added halves use it by reg_hi
  wire fault_pfx = is_gpr && is_size64 && !pfx_w;
  wire fault = fault_pfx || (cls == ifpd_pkg::ifpd_cls_bad);
  // 32-bit gpr writes clear the upper half
  wire zext = is_gpr && (sz == ifpd_pkg::ifpd_sz_32);
  wire addr16 = (cls == ifpd_pkg::ifpd_cls_addr_calc) &&
                (sz == ifpd_pkg::ifpd_sz_16);
  // fp with integer memory operand is microcoded
  assign micro = (cls == ifpd_pkg::ifpd_cls_fp_ldex_int) ||
                 (cls == ifpd_pkg::ifpd_cls_micro) || addr16;
  // load into temp first, then operate
  wire load_first = (cls == ifpd_pkg::ifpd_cls_int_ldex) ||
                    (cls == ifpd_pkg::ifpd_cls_fp_ldex_fp) ||
                    (cls == ifpd_pkg::ifpd_cls_fp_ldex_int);
  logic [1:0] uops;
  logic [2:0] lat;

  assign len = {1'b0, body_len} + 5'(has_pfx);

  always_comb begin
    uops = ifpd_pkg::UOPS_ONE;
    lat = ifpd_pkg::LAT_BASE;
    weight = ifpd_pkg::W_SINGLE;
    if (micro) begin
      weight = ifpd_pkg::W_MICRO;
      uops = (cls == ifpd_pkg::ifpd_cls_fp_ldex_int) ?
             ifpd_pkg::UOPS_TWO : ifpd_pkg::UOPS_MICRO;
    end else if (cls == ifpd_pkg::ifpd_cls_double) begin
      weight = ifpd_pkg::W_DOUBLE;
      uops = ifpd_pkg::UOPS_TWO;
    end else if (cls == ifpd_pkg::ifpd_cls_addr_calc) begin
      lat = ifpd_pkg::LAT_ADDR_CALC;
    end
  end

  // {fault,zext,load_first,lat,uops,sz,reg,cls,micro}
  // top bit spare; keeps the packed slot at its full width
  assign fields = {1'b0, fault, zext, load_first, lat, uops, sz, reg_idx,
                   cls, micro, 1'b1};
endmodule // ifpd_slot_dec
`default_nettype wire

// ===== testbench/ifpd_cache_model.sv
`timescale 1ns/1ps
`default_nettype none
module ifpd_cache_model (
  input wire logic ref_clk,
  input wire logic [59:0] fetch_line,
  input wire logic pkt_ready,
  input wire logic slow,
  output logic pkt_valid,
  output logic [127:0] pkt_data
);
  logic [7:0] mem [0:511];
  int last_line = 0;
  int cnt = 0;
  logic tk;
  initial begin
    pkt_valid = 1'b0;
    pkt_data = '1;
  end
  always @(posedge ref_clk) begin
    tk = pkt_valid && pkt_ready;
    #1;
    cnt++;
    // offer held until taken; slow offers every 4th cycle
    if (tk || !pkt_valid)
      pkt_valid = int'(fetch_line) < last_line && (!slow || cnt % 4 == 0);
    for (int i = 0; i < 16; i++)
      pkt_data[8*i+:8] = pkt_valid ? mem[{fetch_line[4:0], 4'(i)}]
        : ~pkt_data[8*i+:8];
  end
endmodule // ifpd_cache_model
`default_nettype wire

// ===== testbench/ifpd_front_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ifpd_front_asserts (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic redirect_valid,
  input wire logic [59:0] fetch_line,
  input wire logic pkt_valid,
  input wire logic pkt_ready,
  input wire logic dec_valid,
  input wire logic [2:0] dec_slot_valid,
  input wire logic [2:0] dec_micro,
  input wire logic [8:0] dec_class,
  input wire logic [5:0] dec_uops,
  input wire logic [8:0] dec_lat,
  input wire logic wb_valid,
  input wire logic [1:0] wb_size,
  input wire logic wb_out_valid,
  input wire logic [63:0] wb_out_data
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // half-slot units halved: a double counts twice
  logic [2:0] heavy;
  always_comb begin
    heavy = 3'h0;
    for (int i = 0; i < 3; i++)
      heavy = heavy + {2'h0, dec_slot_valid[i]}
        + {2'h0, dec_slot_valid[i] && dec_class[3*i+:3] == 3'h2};
  end
  sequence s_take;
    pkt_valid && pkt_ready;
  endsequence
  sequence s_wb32;
    wb_valid && wb_size == 2'h1;
  endsequence
  property p_line_step;
    s_take |=> fetch_line == $past(fetch_line) + 60'h1;
  endproperty
  a_line_step: assert property (p_line_step) else $error("line step");
  property p_ready_redir;
    redirect_valid |-> !pkt_ready;
  endproperty
  a_ready_redir: assert property (p_ready_redir) else $error("ready");
  property p_order;
    dec_valid |-> dec_slot_valid inside {3'h1, 3'h3, 3'h7};
  endproperty
  a_order: assert property (p_order) else $error("slot order");
  property p_budget;
    dec_valid |-> heavy <= 3'h3;
  endproperty
  a_budget: assert property (p_budget) else $error("budget");
  property p_micro;
    dec_valid && (dec_micro & dec_slot_valid) != 3'h0
      |-> dec_slot_valid == 3'h1;
  endproperty
  a_micro: assert property (p_micro) else $error("micro alone");
  property p_lea;
    dec_valid && dec_slot_valid[0] && dec_class[2:0] == 3'h5
      && !dec_micro[0] |-> dec_lat[2:0] == 3'h2;
  endproperty
  a_lea: assert property (p_lea) else $error("addr latency");
  property p_fpint;
    dec_valid && dec_slot_valid[0] && dec_class[2:0] == 3'h4
      |-> dec_micro[0] && dec_uops[1:0] == 2'h2;
  endproperty
  a_fpint: assert property (p_fpint) else $error("fp int route");
  property p_zext;
    s_wb32 |=> wb_out_valid ##0 wb_out_data[63:32] == 32'h0;
  endproperty
  a_zext: assert property (p_zext) else $error("zero ext");
endmodule // ifpd_front_asserts
`default_nettype wire

// ===== testbench/instruction_fetch_pick_decode_tb.sv
`timescale 1ns/1ps
`default_nettype none
module instruction_fetch_pick_decode_tb;
  logic ref_clk, arst_n, mode64, redirect_valid, pkt_valid, pkt_ready;
  logic dec_valid, dec_ready, wb_valid, wb_out_valid, slow, stall, go;
  logic [63:0] redirect_addr, wb_data, wb_old, wb_out_data;
  logic [59:0] fetch_line;
  logic [127:0] pkt_data;
  logic [2:0] dec_slot_valid, dec_micro, dec_load_first, dec_zext;
  logic [2:0] dec_fault;
  logic [8:0] dec_class, dec_lat;
  logic [11:0] dec_reg;
  logic [5:0] dec_size, dec_uops;
  logic [1:0] wb_size;
  logic [17:0] eq[$];
  logic [63:0] wq[$];
  int err_count = 0;
  int compares = 0;
  int a;
  integer seed = 32'hf1d19407;
  ifpd_front dut (.ref_clk, .arst_n, .mode64, .redirect_valid,
    .redirect_addr, .fetch_line, .pkt_valid, .pkt_ready, .pkt_data,
    .dec_valid, .dec_ready, .dec_slot_valid, .dec_micro, .dec_class,
    .dec_reg, .dec_size, .dec_uops, .dec_lat, .dec_load_first,
    .dec_zext, .dec_fault, .wb_valid, .wb_size, .wb_data, .wb_old,
    .wb_out_valid, .wb_out_data);
  ifpd_cache_model cache (.ref_clk, .fetch_line, .pkt_ready, .slow,
    .pkt_valid, .pkt_data);
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic chk(string n, logic [63:0] e, logic [63:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic put(logic [2:0] c, logic [1:0] sz, logic [1:0] rf,
    logic [2:0] rg, logic [3:0] ln, logic p, logic w, logic b);
    logic mi;
    mi = c == 3'h4 || c == 3'h6 || (c == 3'h5 && sz == 2'h0);
    if (p) begin
      cache.mem[a[8:0]] = {4'h4, w, 2'h0, b};
      a++;
    end
    cache.mem[a[8:0]] = {1'b0, c, ln};
    cache.mem[9'(a + 1)] = {rg, rf, 1'b0, sz};
    for (int i = 2; i < ln; i++) cache.mem[9'(a + i)] = 8'($random(seed));
    a += ln;
    eq.push_back({mi, c, rf == 2'h2 ? 1'b0 : p && b, rg, sz,
      mi ? (c == 3'h4 ? 2'h2 : 2'h3) : (c == 3'h2 ? 2'h2 : 2'h1),
      c == 3'h5 && !mi ? 3'h2 : 3'h1, c == 3'h1 || c == 3'h3 || c == 3'h4,
      rf == 2'h0 && sz == 2'h1,
      (rf == 2'h0 && sz == 2'h2 && !(p && w)) || c == 3'h7});
  endtask
  task automatic run(int t, logic m, logic [63:0] st, int n, logic s);
    logic [15:0] r;
    mode64 = m;
    a = int'(st);
    repeat (n) begin
      r = 16'($random(seed));
      // a class-4 header reads as a prefix in 64-bit mode: always prefix it
      put(r[2:0], r[4:3], r[6:5], r[9:7], 4'h2 + 4'(r[11:10]),
        m && (r[12] || r[2:0] == 3'h4), r[13], r[14]);
    end
    // pad to a packet edge so no stray bytes follow the program
    while (a % 16 != 0)
      put(3'h0, 2'h1, 2'h0, 3'h1, a % 16 == 15 ? 4'h2 : 4'(16 - a % 16),
        1'b0, 1'b0, 1'b0);
    redirect_valid = 1'b1;
    redirect_addr = st;
    cache.last_line = a / 16;
    slow = s;
    stall = s;
    @(posedge ref_clk);
    #1 redirect_valid = 1'b0;
    if (s) begin
      repeat (24) @(posedge ref_clk);
      chk("fill ready", 64'h0, {63'h0, pkt_ready});
      chk("fill valid", 64'h1, {63'h0, dec_valid});
      stall = 1'b0;
    end
    for (int k = 0; k < 3000 && eq.size() != 0; k++) @(posedge ref_clk);
    chk("left", 64'h0, 64'(eq.size()));
    #1 $display("test %0d done", t);
  endtask
  task automatic results;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    #1;
    dec_ready = !stall && $random(seed) % 4 != 0;
    wb_valid = go && $random(seed) % 2 != 0;
    wb_size = 2'($random(seed));
    wb_data = {$random(seed), $random(seed)};
    wb_old = {$random(seed), $random(seed)};
    if (wb_valid)
      wq.push_back(wb_size == 2'h2 ? wb_data : wb_size == 2'h1
        ? {32'h0, wb_data[31:0]} : wb_size == 2'h0
        ? {wb_old[63:16], wb_data[15:0]} : {wb_old[63:8], wb_data[7:0]});
  end
  always @(posedge ref_clk) begin
    if (wb_out_valid === 1'b1) chk("wb", wq.pop_front(), wb_out_data);
    if (dec_valid === 1'b1 && dec_ready === 1'b1)
      for (int i = 0; i < 3; i++)
        if (dec_slot_valid[i] === 1'b1)
          chk("slot", eq.pop_front(), {46'h0, dec_micro[i],
            dec_class[3*i+:3], dec_reg[4*i+:4], dec_size[2*i+:2],
            dec_uops[2*i+:2], dec_lat[3*i+:3], dec_load_first[i],
            dec_zext[i], dec_fault[i]});
  end
  initial begin
    {arst_n, mode64, redirect_valid, slow, stall, go} = 6'h0;
    redirect_addr = '0;
    repeat (5) @(posedge ref_clk);
    #1 arst_n = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 go = 1'b1;
    run(1, 1'b1, 64'h23, 30, 1'b0);
    run(2, 1'b1, 64'h7, 30, 1'b1);
    run(3, 1'b0, 64'h50, 30, 1'b0);
    results;
  end
  initial begin
    #300000;
    err_count++;
    results;
  end
endmodule // instruction_fetch_pick_decode_tb
bind ifpd_front ifpd_front_asserts u_chk (.ref_clk, .arst_n,
  .redirect_valid, .fetch_line, .pkt_valid, .pkt_ready, .dec_valid,
  .dec_slot_valid, .dec_micro, .dec_class, .dec_uops, .dec_lat,
  .wb_valid, .wb_size, .wb_out_valid, .wb_out_data);
`default_nettype wire
